//--- src/data_eeprom_write_control.sv
/*
 data_eeprom_write_control: register front end and write sequencer for the
 on-chip data eeprom (byte write with pre-erase, 16-byte page write).
 assumes an eeprom array that times each cycle itself and answers every
 array_start_o pulse with one array_done_i pulse, synchronous to mclk_i.
*/
// The placing of the registers and the Avalon-MM slave port were decided locally.
// Summary of operation
// [RULE1] array timer runs alone; completion seen only
// [RULE2] start bit clears when cycle ends
// [RULE3] permit bit clears after every write
// [RULE4] byte mode erases the byte first
// [RULE5] mode high programs page from buffer
// [RULE6] page buffer cleared at power-on
// [RULE7] permit fall clears buffer, rise keeps
// [RULE8] upper five bits page, lower four offset
// [RULE9] page writes increment offset, never page
// [RULE10] offset holds at 0FH, later writes ignored
// [RULE11] data byte stored before offset increments
// [RULE12] software sets permit then start next
// [RULE13] start without permit starts nothing
// [RULE14] software masks interrupts during activation
// [RULE15] software erases page before page write
// [RULE16] permit bit zero after power-on
// [RULE17] pointer high bytes zero after power-on
// [RULE18] flag set when a cycle ends
// [RULE19] vector needs all enables, stack free
// [RULE20] flag cleared when interrupt serviced
// [RULE21] software avoids sleep during operation
// [RULE22] software never sets write and read start
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_write_control import nvm_pkg::*; (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output array_cmd_s array_cmd_o,
	output logic array_start_o,
	output logic [8*PAGE_BYTES-1:0] page_data_o,
	output logic [PAGE_BYTES-1:0] page_mask_o,
	input wire logic array_done_i,
	input wire logic stack_full_i,
	input wire logic irq_ack_i,
	output logic irq_req_o
);
	typedef enum logic [1:0] {S_IDLE, S_ERASE, S_PROG} seq_e;
	logic wait_q;
	logic [31:0] rdata_q, rdata_d;
	logic mode_q, permit_q, permit_d, start_q, armed_q;
	logic addr_hi_q;
	logic [7:0] addr_lo_q, data_q, ptr1_q, ptr2_q;
	logic page_full_q;
	logic [7:0] buf_q [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mask_q;
	logic irq_permit_q, mf_permit_q, global_q, flag_q, irq_q;
	seq_e state_q;
	array_cmd_s cmd_q;
	logic cmd_start_q;
	logic wr_take, rd_take, busy, sector_ok, ctrl_wr, data_wr, page_wr, accept, prog_done;
	logic [7:0] wd;
	logic [OFS_W-1:0] ofs;
	logic [PAGE_W-1:0] page;
	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a[4:2] == off[4:2]);
	endfunction : hit
	assign wd = avs_writedata_i[7:0];
	assign wr_take = avs_write_i && !wait_q && avs_byteenable_i[0];
	assign rd_take = avs_read_i && wait_q;
	assign busy = (state_q != S_IDLE);
	// control register writes only taken while a pointer selects its sector; reads are not gated
	assign sector_ok = (ptr1_q == NVM_SECTOR) || (ptr2_q == NVM_SECTOR);
	assign ctrl_wr = wr_take && hit(avs_address_i, OFF_CTRL) && sector_ok && !busy;
	assign data_wr = wr_take && hit(avs_address_i, OFF_DATA) && !busy;
	assign page = {addr_hi_q, addr_lo_q[7:OFS_W]}; // RULE8
	assign ofs = addr_lo_q[OFS_W-1:0]; // RULE8
	assign page_wr = data_wr && mode_q && !page_full_q; // RULE10
	// start only straight after the write that raised permit
	assign accept = ctrl_wr && wd[CTRL_START_BIT] && wd[CTRL_PERMIT_BIT] && permit_q
		&& armed_q; // RULE12 RULE13
	assign prog_done = (state_q == S_PROG) && array_done_i;
	// bus answer: one wait cycle, then the request is taken
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			wait_q <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end
	always_comb begin
		rdata_d = RST_WORD;
		if (hit(avs_address_i, OFF_CTRL)) begin
			rdata_d[CTRL_MODE_BIT] = mode_q;
			rdata_d[CTRL_PERMIT_BIT] = permit_q;
			rdata_d[CTRL_START_BIT] = start_q; // RULE1
		end else if (hit(avs_address_i, OFF_ADDR_HI)) begin
			rdata_d[0] = addr_hi_q;
		end else if (hit(avs_address_i, OFF_ADDR_LO)) begin
			rdata_d[7:0] = addr_lo_q;
		end else if (hit(avs_address_i, OFF_DATA)) begin
			rdata_d[7:0] = data_q;
		end else if (hit(avs_address_i, OFF_IRQ)) begin
			rdata_d[3:0] = {flag_q, global_q, mf_permit_q, irq_permit_q};
		end else if (hit(avs_address_i, OFF_PTR1)) begin
			rdata_d[7:0] = ptr1_q;
		end else if (hit(avs_address_i, OFF_PTR2)) begin
			rdata_d[7:0] = ptr2_q;
		end else begin
			rdata_d[3:0] = {page_full_q, state_q == S_PROG, state_q == S_ERASE, busy};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rdata_q <= RST_WORD;
		end else if (rd_take) begin
			rdata_q <= rdata_d;
		end
	end
	always_comb begin
		permit_d = permit_q;
		if (prog_done) begin
			permit_d = 1'b0; // RULE3
		end else if (ctrl_wr) begin
			permit_d = wd[CTRL_PERMIT_BIT];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			permit_q <= 1'b0; // RULE16
			mode_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			permit_q <= permit_d;
			if (ctrl_wr) begin
				mode_q <= wd[CTRL_MODE_BIT];
			end
			if (wr_take) begin
				armed_q <= ctrl_wr && wd[CTRL_PERMIT_BIT] && !permit_q; // RULE12
			end
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			start_q <= 1'b0;
		end else if (prog_done) begin
			start_q <= 1'b0; // RULE2
		end else if (accept) begin
			start_q <= 1'b1;
		end
	end
	// pointer high bytes guard the control register sector
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ptr1_q <= RST_BYTE; // RULE17
			ptr2_q <= RST_BYTE; // RULE17
		end else if (wr_take && hit(avs_address_i, OFF_PTR1)) begin
			ptr1_q <= wd;
		end else if (wr_take && hit(avs_address_i, OFF_PTR2)) begin
			ptr2_q <= wd;
		end
	end
	// address and data registers frozen while a cycle runs
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			addr_hi_q <= 1'b0;
			addr_lo_q <= RST_BYTE;
			data_q <= RST_BYTE;
			page_full_q <= 1'b0;
		end else begin
			if (wr_take && !busy && hit(avs_address_i, OFF_ADDR_HI)) begin
				addr_hi_q <= wd[0];
			end
			if (wr_take && !busy && hit(avs_address_i, OFF_ADDR_LO)) begin
				addr_lo_q <= wd;
				page_full_q <= 1'b0;
			end else if (permit_q && !permit_d) begin
				page_full_q <= 1'b0;
			end else if (page_wr) begin
				if (ofs == OFS_LAST) begin
					page_full_q <= 1'b1; // RULE10
				end else begin
					addr_lo_q[OFS_W-1:0] <= ofs + 4'h1; // RULE9
				end
			end
			if (data_wr && !(mode_q && page_full_q)) begin
				data_q <= wd;
			end
		end
	end
	// page buffer; mask marks the bytes tagged since the last clear
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			mask_q <= '0; // RULE6
		end else if (permit_q && !permit_d) begin
			mask_q <= '0; // RULE7
		end else if (page_wr) begin
			mask_q[ofs] <= 1'b1; // RULE11
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				buf_q[i] <= RST_BYTE; // RULE6
			end
		end else if (permit_q && !permit_d) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				buf_q[i] <= RST_BYTE; // RULE7
			end
		end else if (page_wr) begin
			buf_q[ofs] <= wd; // RULE11
		end
	end
	for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_pack
		assign page_data_o[8*g +: 8] = buf_q[g];
	end
	// sequencer: waits on the array's own timer, no cycle count here
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			state_q <= S_IDLE;
			cmd_q <= '0;
			cmd_start_q <= 1'b0;
		end else begin
			cmd_start_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (accept) begin
						cmd_q.op <= mode_q ? OP_PROGRAM : OP_ERASE; // RULE4 RULE5
						cmd_q.page_mode <= mode_q; // RULE5
						cmd_q.page <= page;
						cmd_q.offset <= ofs;
						cmd_q.data <= data_q;
						cmd_start_q <= 1'b1;
						state_q <= mode_q ? S_PROG : S_ERASE;
					end
				end
				S_ERASE: begin
					if (array_done_i) begin
						cmd_q.op <= OP_PROGRAM; // RULE4
						cmd_start_q <= 1'b1;
						state_q <= S_PROG;
					end
				end
				S_PROG: begin
					if (array_done_i) begin
						state_q <= S_IDLE; // RULE1
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			irq_permit_q <= 1'b0;
			mf_permit_q <= 1'b0;
			global_q <= 1'b0;
		end else if (wr_take && hit(avs_address_i, OFF_IRQ)) begin
			irq_permit_q <= wd[IRQ_PERMIT_BIT];
			mf_permit_q <= wd[IRQ_MF_PERMIT_BIT];
			global_q <= wd[IRQ_GLOBAL_BIT]; // RULE14
		end
	end
	// set wins over service or write-one clear
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			flag_q <= 1'b0;
		end else if (prog_done) begin
			flag_q <= 1'b1; // RULE18
		end else if (irq_ack_i || (wr_take && hit(avs_address_i, OFF_IRQ) && wd[IRQ_FLAG_BIT])) begin
			flag_q <= 1'b0; // RULE20
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && irq_permit_q && mf_permit_q && global_q && !stack_full_i
				&& !irq_ack_i; // RULE19
		end
	end
	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign array_cmd_o = cmd_q;
	assign array_start_o = cmd_start_q;
	assign page_mask_o = mask_q;
	assign irq_req_o = irq_q;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	start_clear_a: assert property (prog_done |=> !start_q && state_q == S_IDLE) // RULE2
		else $error("start bit not cleared at end of cycle");
	permit_clear_a: assert property (prog_done |=> !permit_q) // RULE3
		else $error("permit bit not cleared after write");
	pre_erase_a: assert property (accept && !mode_q |=> array_start_o && array_cmd_o.op == OP_ERASE
		##1 !array_start_o) // RULE4
		else $error("byte write did not erase first");
	page_prog_a: assert property (accept && mode_q |=> array_start_o
		&& array_cmd_o.op == OP_PROGRAM && array_cmd_o.page_mode) // RULE5
		else $error("page write not issued as page program");
	buf_clear_a: assert property (permit_q && !permit_d |=> page_mask_o == '0) // RULE7
		else $error("buffer kept after permit fell");
	ofs_step_a: assert property (page_wr && ofs != OFS_LAST |=> ofs == $past(ofs) + 4'h1
		&& page == $past(page) && page_mask_o[$past(ofs)]) // RULE9
		else $error("in-page offset did not step");
	ofs_hold_a: assert property (page_full_q && data_wr |=> ofs == OFS_LAST
		&& page_mask_o == $past(page_mask_o)) // RULE10
		else $error("write past page end took effect");
	no_permit_a: assert property (state_q == S_IDLE && !permit_q |=> state_q == S_IDLE
		&& !array_start_o) // RULE13
		else $error("cycle began without permit");
	power_on_a: assert property ($rose(rstn_i) |-> !permit_q && ptr1_q == RST_BYTE
		&& ptr2_q == RST_BYTE && page_mask_o == '0) // RULE16
		else $error("power-on state wrong");
	flag_set_a: assert property (prog_done |=> flag_q) // RULE18
		else $error("flag not set at cycle end");
	irq_gate_a: assert property (irq_req_o |-> $past(flag_q) && $past(global_q)
		&& $past(mf_permit_q) && $past(irq_permit_q) && !$past(stack_full_i)) // RULE19
		else $error("interrupt raised without all enables");
	ack_clear_a: assert property (irq_ack_i && !prog_done |=> !flag_q) // RULE20
		else $error("flag not cleared on service");
	byte_write_c: cover property (accept && !mode_q ##[1:50] prog_done);
	page_write_c: cover property (accept && mode_q && page_mask_o != '0);
	irq_c: cover property (prog_done ##2 irq_req_o);
endmodule : data_eeprom_write_control
`default_nettype wire

//--- src/nvm_pkg.sv
/*
 nvm_pkg: register offsets, field positions, reset values and shared types
 for the data eeprom write controller.
 assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package nvm_pkg;
	// register byte offsets
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_ADDR_HI = 5'h04;
	localparam logic [4:0] OFF_ADDR_LO = 5'h08;
	localparam logic [4:0] OFF_DATA = 5'h0C;
	localparam logic [4:0] OFF_IRQ = 5'h10;
	localparam logic [4:0] OFF_PTR1 = 5'h14;
	localparam logic [4:0] OFF_PTR2 = 5'h18;
	localparam logic [4:0] OFF_STAT = 5'h1C;
	// nvm_control_register fields
	localparam int CTRL_MODE_BIT = 4;
	localparam int CTRL_PERMIT_BIT = 3;
	localparam int CTRL_START_BIT = 2;
	// irq register fields
	localparam int IRQ_PERMIT_BIT = 0;
	localparam int IRQ_MF_PERMIT_BIT = 1;
	localparam int IRQ_GLOBAL_BIT = 2;
	localparam int IRQ_FLAG_BIT = 3;
	// address layout
	localparam int OFS_W = 4;
	localparam int PAGE_W = 5;
	localparam int PAGE_BYTES = 16;
	localparam logic [OFS_W-1:0] OFS_LAST = 4'hF;
	localparam logic [7:0] NVM_SECTOR = 8'h01;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic {OP_ERASE, OP_PROGRAM} nvm_op_e;

	typedef struct packed {
		nvm_op_e op;
		logic page_mode;
		logic [PAGE_W-1:0] page;
		logic [OFS_W-1:0] offset;
		logic [7:0] data;
	} array_cmd_s;
endpackage : nvm_pkg

//--- testbench/nvm_array_model.sv
/*
 nvm_array_model: behavioural eeprom array, one done pulse per start pulse.
 assumes start and done are synchronous to the bench clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire logic [3:0] dly_i,
	output logic done_o
);
	logic [4:0] cnt_q;
	logic busy_q;
	// own timer, unrelated to bus traffic; dly_i sets a delay of 1 to 16 cycles
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			busy_q <= 1'b0;
			cnt_q <= 5'h00;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				busy_q <= 1'b1;
				cnt_q <= {1'b0, dly_i};
			end else if (busy_q && cnt_q == 5'h00) begin
				busy_q <= 1'b0;
				done_o <= 1'b1;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end
endmodule : nvm_array_model
`default_nettype wire

//--- testbench/testbench.sv
/*
 testbench: random and corner byte and page writes over the avalon-mm port.
 assumes the write controller, its package and nvm_array_model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench import nvm_pkg::*; ();
	logic clk, rstn, rd, wr, done, sfull, ack, wait_r, st, irq;
	logic [4:0] adr;
	logic [31:0] wd, rdat, q;
	logic [3:0] be, dly;
	logic [127:0] pdata;
	logic [15:0] pmask, exp_mask;
	logic [8:0] a;
	logic [7:0] d [5];
	array_cmd_s cmd;
	array_cmd_s ops [$];
	int miscompares, total_checks;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
	data_eeprom_write_control i_data_eeprom_write_control (.mclk_i(clk), .rstn_i(rstn),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
		.array_cmd_o(cmd), .array_start_o(st), .page_data_o(pdata), .page_mask_o(pmask),
		.array_done_i(done), .stack_full_i(sfull), .irq_ack_i(ack), .irq_req_o(irq));
	nvm_array_model i_nvm_array_model (.clk_i(clk), .rstn_i(rstn), .start_i(st),
		.dly_i(dly), .done_o(done));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (rstn && st) ops.push_back(cmd);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	// request held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] dat);
		int n;
		n = 0;
		adr <= ad;
		wd <= dat;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		if (n >= 50) begin
			miscompares++;
			complete_run();
		end
		// taken at the edge that saw waitrequest low, released only then
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			bus(1'b0, OFF_CTRL, 32'h0);
			n++;
		end while (q[CTRL_START_BIT] !== 1'b0 && n < 200);
		if (n >= 200) begin
			miscompares++;
			complete_run();
		end
	endtask : wait_idle
	task automatic activate(input logic m);
		bus(1'b1, OFF_IRQ, 32'h0000_0003);
		bus(1'b1, OFF_CTRL, {27'h0, m, 4'h8});
		if (m) `CHK("mask_keep", exp_mask, pmask)
		bus(1'b1, OFF_CTRL, {27'h0, m, 4'hC});
		bus(1'b1, OFF_IRQ, 32'h0000_0007);
		// polls only, never idles the core while a cycle runs
		wait_idle();
	endtask : activate
	initial begin
		int i, k;
		{rstn, rd, wr, sfull, ack} = 5'h00;
		{adr, wd, dly, exp_mask} = '0;
		be = 4'hF;
		miscompares = 0;
		total_checks = 0;
		void'($urandom(32'h6d64d7d1));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		`CHK("buf_rst", 144'h0, {pdata, pmask})
		bus(1'b0, OFF_CTRL, 32'h0);
		`CHK("permit_rst", 1'b0, q[CTRL_PERMIT_BIT])
		bus(1'b0, OFF_PTR1, 32'h0);
		`CHK("ptr1_rst", 8'h00, q[7:0])
		bus(1'b0, OFF_PTR2, 32'h0);
		`CHK("ptr2_rst", 8'h00, q[7:0])
		// start alone, permit still low
		bus(1'b1, OFF_PTR1, 32'h0000_0001);
		bus(1'b1, OFF_CTRL, 32'h0000_0004);
		bus(1'b0, OFF_CTRL, 32'h0);
		`CHK("no_start", 0, ops.size())
		`CHK("start_bit", 1'b0, q[CTRL_START_BIT])
		for (i = 0; i < 4; i++) begin
			a = (i == 0) ? 9'h1FF : 9'($urandom);
			d[0] = (i == 0) ? 8'hFF : 8'($urandom);
			dly <= 4'($urandom);
			bus(1'b1, OFF_ADDR_HI, {31'h0, a[8]});
			bus(1'b1, OFF_ADDR_LO, {24'h0, a[7:0]});
			bus(1'b1, OFF_DATA, {24'h0, d[0]});
			ops.delete();
			activate(1'b0);
			`CHK("op_count", 2, ops.size())
			`CHK("op_erase", OP_ERASE, ops[0].op)
			`CHK("op_prog", OP_PROGRAM, ops[1].op)
			`CHK("target", {a, d[0]}, {ops[1].page, ops[1].offset, ops[1].data})
			bus(1'b0, OFF_CTRL, 32'h0);
			`CHK("permit_clr", 1'b0, q[CTRL_PERMIT_BIT])
			bus(1'b0, OFF_IRQ, 32'h0);
			`CHK("flag_set", 1'b1, q[IRQ_FLAG_BIT])
			`CHK("irq_on", 1'b1, irq)
			if (i == 0) begin
				sfull <= 1'b1;
				repeat (3) @(posedge clk);
				`CHK("irq_full", 1'b0, irq)
				sfull <= 1'b0;
			end
			ack <= 1'b1;
			@(posedge clk);
			ack <= 1'b0;
			@(posedge clk);
			bus(1'b0, OFF_IRQ, 32'h0);
			`CHK("flag_clr", 1'b0, q[IRQ_FLAG_BIT])
		end
		// page write from offset 0xD: three bytes fit, two are dropped
		bus(1'b1, OFF_CTRL, 32'h0000_0010);
		// array model holds no old data, so every page counts as erased
		a = {5'($urandom), 4'hD};
		bus(1'b1, OFF_ADDR_HI, {31'h0, a[8]});
		bus(1'b1, OFF_ADDR_LO, {24'h0, a[7:0]});
		for (k = 0; k < 5; k++) begin
			d[k] = 8'($urandom);
			bus(1'b1, OFF_DATA, {24'h0, d[k]});
		end
		exp_mask = 16'hE000;
		`CHK("page_mask", exp_mask, pmask)
		`CHK("page_bytes", {d[2], d[1], d[0]}, pdata[127:104])
		bus(1'b0, OFF_STAT, 32'h0);
		`CHK("page_full", 1'b1, q[3])
		ops.delete();
		activate(1'b1);
		`CHK("page_ops", 1, ops.size())
		`CHK("page_cmd", {OP_PROGRAM, 1'b1, a[8:4]}, {ops[0].op, ops[0].page_mode, ops[0].page})
		`CHK("page_ofs", OFS_LAST, ops[0].offset)
		`CHK("mask_clr", 16'h0000, pmask)
		complete_run();
	end
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule : testbench
`default_nettype wire
